// ### rtl/dee_pkg.sv
// Package for the data EEPROM access control block
package dee_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] DEE_CTRL_OFS   = 8'h00;
  localparam logic [7:0] DEE_KEY_OFS    = 8'h04;
  localparam logic [7:0] DEE_LOC_OFS    = 8'h08;
  localparam logic [7:0] DEE_BYTE_OFS   = 8'h0c;
  localparam logic [7:0] DEE_STATUS_OFS = 8'h10;

  // ****************************************
  // Control and status field positions and register reset values
  // ****************************************
  localparam int DEE_FETCH_BIT   = 0;
  localparam int DEE_GO_BIT      = 1;
  localparam int DEE_ALLOW_BIT   = 2;
  localparam int DEE_ABORT_BIT   = 3;
  localparam int DEE_ROW_BIT     = 4;
  localparam int DEE_CFG_BIT     = 6;
  localparam int DEE_PSPACE_BIT  = 7;
  localparam int DEE_DONE_BIT    = 0;
  localparam logic [7:0] DEE_CTRL_RST = 8'h00;
  localparam logic [7:0] DEE_LOC_RST  = 8'h00;
  localparam logic [7:0] DEE_BYTE_RST = 8'h00;

  // ****************************************
  // Unlock keys
  // ****************************************
  localparam logic [7:0] DEE_KEY1 = 8'h55;
  localparam logic [7:0] DEE_KEY2 = 8'haa;

  // ****************************************
  // Timing
  // ****************************************
  localparam int DEE_CLK_PERIOD_NS = 50;
  localparam int DEE_PROG_TIME_US  = 4000;
  localparam int DEE_PROG_CYCLES   = (DEE_PROG_TIME_US * 1000) / DEE_CLK_PERIOD_NS;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic prog_sel;
    logic cfg_sel;
    logic rsvd;
    logic row_erase;
    logic abort;
    logic allow;
    logic go;
    logic fetch;
  } dee_ctrl_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } dee_apb_req_s;

  typedef enum logic [1:0] {KEY_IDLE, KEY_GOT1, KEY_GOT2} dee_key_e;
  typedef enum logic {PRG_IDLE, PRG_BUSY} dee_prg_e;

endpackage

// ### rtl/dee_access_ctrl.sv
// Data EEPROM access control: APB registers, unlock, fetch and timed program
// Behaviour
// RULE1: Fetch go loads byte register next cycle
// RULE2: Byte register holds until fetch or write
// RULE3: Config select steers away from data array
// RULE4: Row erase on program go, cleared after
// RULE5: Pin or watchdog reset mid-cycle sets abort
// RULE6: Abort keeps space and row erase bits
// RULE7: No cycle without allow; never auto-cleared
// RULE8: Allow must precede go in earlier write
// RULE9: Keys 55h then AAh then go
// RULE10: Busy cycle locks control, location, byte
// RULE11: Cycle end clears go, sets done
// RULE12: Done flag cleared only by software
// RULE13: Software loads location and byte first
// RULE14: Software disables interrupts around unlock
// RULE15: Software keeps allow clear normally
// RULE16: Space select picks data or program
// RULE17: Fetch refused while program space selected
// RULE18: Key port stores nothing, reads zero
// RULE19: Interrupting reset clears location and byte
// RULE20: Counter times cycle; bit 5 zero
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module dee_access_ctrl
  import dee_pkg::*;
#(
  parameter int DEPTH      = 256,
  parameter int PROG_COUNT = DEE_PROG_CYCLES
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic [31:0]               prdata,
  input  wire logic                 pin_reset_req,
  input  wire logic                 wdt_reset_req,
  output logic                      nvm_busy,
  output logic                      pmem_row_erase,
  output logic                      nvm_done_flag
);
  import dee_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(PROG_COUNT + 1);
  localparam logic [CW-1:0] LAST = CW'(PROG_COUNT - 1);

  // ****************************************
  // Bus decode
  // ****************************************
  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == DEE_CTRL_OFS) || (a == DEE_KEY_OFS) || (a == DEE_LOC_OFS)
              || (a == DEE_BYTE_OFS) || (a == DEE_STATUS_OFS);
  endfunction

  dee_apb_req_s req;
  logic         wr_acc;
  logic         rd_setup;
  logic         rst_req;

  assign req      = '{psel, penable, pwrite, paddr, pwdata};
  assign pready   = req.psel & req.penable;
  assign pslverr  = pready & ~known_addr(req.paddr);
  assign wr_acc   = pready & req.pwrite & known_addr(req.paddr);
  assign rd_setup = req.psel & ~req.penable & ~req.pwrite;
  assign rst_req  = pin_reset_req | wdt_reset_req;

  // ****************************************
  // State
  // ****************************************
  dee_ctrl_s           ctrl_q, ctrl_d;
  logic [7:0]          loc_q, loc_d;
  logic [7:0]          byte_q, byte_d;
  logic                done_q, done_d;
  dee_key_e            key_q, key_d;
  dee_prg_e            prg_q, prg_d;
  logic [CW-1:0]       cnt_q, cnt_d;
  logic [31:0]         rdata_q, rdata_d;
  logic [7:0]          mem_q [DEPTH];
  logic                commit;
  logic                prog_end;
  logic                data_target;
  logic [AW-1:0]       idx;

  assign idx         = loc_q[AW-1:0];
  assign data_target = ~ctrl_q.prog_sel & ~ctrl_q.cfg_sel;

  // ****************************************
  // Control, unlock and timing
  // ****************************************
  always_comb begin
    dee_ctrl_s wctl;
    logic      start;
    wctl    = dee_ctrl_s'(req.pwdata[7:0]);
    start   = 1'b0;
    ctrl_d  = ctrl_q;
    loc_d   = loc_q;
    byte_d  = byte_q;
    prg_d   = prg_q;
    cnt_d   = cnt_q;
    commit  = 1'b0;
    prog_end = 1'b0;
    ctrl_d.fetch = 1'b0;

    // RULE10: control, location and byte writes locked while busy
    if (prg_q == PRG_IDLE && wr_acc) begin
      case (req.paddr)
        DEE_CTRL_OFS: begin
          ctrl_d.prog_sel  = wctl.prog_sel;
          ctrl_d.cfg_sel   = wctl.cfg_sel;
          ctrl_d.row_erase = wctl.row_erase;
          ctrl_d.abort     = wctl.abort;
          ctrl_d.allow     = wctl.allow;
          // RULE7: allow needed to start
          // RULE8: allow from an earlier write
          // RULE9: go only after both keys
          start = wctl.go & ctrl_q.allow & (key_q == KEY_GOT2);
          // RULE1: fetch loads byte at once
          // RULE17: refused in program space
          // RULE3: config space leaves array alone
          if (wctl.fetch && !wctl.prog_sel && !wctl.cfg_sel) begin
            byte_d = mem_q[idx];
          end
        end
        // RULE2: byte held until reload
        DEE_LOC_OFS:  loc_d  = req.pwdata[7:0];
        DEE_BYTE_OFS: byte_d = req.pwdata[7:0];
        default: ;
      endcase
    end

    case (prg_q)
      PRG_IDLE: begin
        if (start) begin
          prg_d     = PRG_BUSY;
          cnt_d     = '0;
          ctrl_d.go = 1'b1;
        end
      end
      PRG_BUSY: begin
        // RULE20: self-timed by cycle counter
        cnt_d = cnt_q + CW'(1);
        if (cnt_q == LAST) begin
          // RULE11: end clears go, sets done
          prg_d     = PRG_IDLE;
          ctrl_d.go = 1'b0;
          prog_end  = 1'b1;
          // RULE4: row erase bit clears on completion
          ctrl_d.row_erase = 1'b0;
          // RULE16: only data space writes the array
          commit = data_target;
        end
      end
      default: prg_d = PRG_IDLE;
    endcase

    // Pin or watchdog reset clears control, location, byte, keys and cycle; done and idle abort are kept; mid-cycle it sets abort, keeps space and row erase
    if (rst_req) begin
      ctrl_d = dee_ctrl_s'(DEE_CTRL_RST);
      prg_d  = PRG_IDLE;
      cnt_d  = '0;
      commit = 1'b0;
      // RULE19: location and byte are cleared too
      loc_d  = DEE_LOC_RST;
      byte_d = DEE_BYTE_RST;
      if (prg_q == PRG_BUSY) begin
        // RULE5: interrupted cycle raises abort
        ctrl_d.abort     = 1'b1;
        // RULE6: space and row erase kept for tracing
        ctrl_d.prog_sel  = ctrl_q.prog_sel;
        ctrl_d.row_erase = ctrl_q.row_erase;
      end else begin
        ctrl_d.abort = ctrl_q.abort;
      end
    end
    ctrl_d.rsvd = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= dee_ctrl_s'(DEE_CTRL_RST);
      loc_q  <= DEE_LOC_RST;
      byte_q <= DEE_BYTE_RST;
      prg_q  <= PRG_IDLE;
      cnt_q  <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      loc_q  <= loc_d;
      byte_q <= byte_d;
      prg_q  <= prg_d;
      cnt_q  <= cnt_d;
    end
  end

  // ****************************************
  // Unlock key sequence
  // ****************************************
  // Any other mapped write in between starts the sequence over
  always_comb begin
    key_d = key_q;
    // RULE9: keys 55h then AAh, nothing between
    if (wr_acc) begin
      key_d = KEY_IDLE;
      if (req.paddr == DEE_KEY_OFS) begin
        if (req.pwdata[7:0] == DEE_KEY1) begin
          key_d = KEY_GOT1;
        end else if (req.pwdata[7:0] == DEE_KEY2 && key_q == KEY_GOT1) begin
          key_d = KEY_GOT2;
        end
      end
    end
    if (rst_req) begin
      key_d = KEY_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_q <= KEY_IDLE;
    end else begin
      key_q <= key_d;
    end
  end

  // ****************************************
  // Completion flag
  // ****************************************
  // Pin and watchdog resets leave it alone so software still sees it
  always_comb begin
    done_d = done_q;
    // RULE12: software write of one clears done
    if (wr_acc && req.paddr == DEE_STATUS_OFS && req.pwdata[DEE_DONE_BIT]) begin
      done_d = 1'b0;
    end
    // RULE11: cycle end sets done, winning over a clear
    if (prog_end) begin
      done_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done_d;
    end
  end

  // ****************************************
  // Data array
  // ****************************************
  // Array contents survive reset, as nonvolatile storage should
  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_cell
      logic [7:0] cell_d;
      always_comb begin
        cell_d = mem_q[i];
        if (commit && idx == AW'(i)) begin
          cell_d = byte_q;
        end
      end
      always_ff @(posedge pclk) begin
        mem_q[i] <= cell_d;
      end
    end
  endgenerate

  // ****************************************
  // Read data
  // ****************************************
  always_comb begin
    rdata_d = rdata_q;
    if (rd_setup) begin
      case (req.paddr)
        // RULE20: bit 5 and fetch read as zero
        DEE_CTRL_OFS:   rdata_d = {24'h000000, ctrl_q.prog_sel, ctrl_q.cfg_sel, 1'b0,
                                   ctrl_q.row_erase, ctrl_q.abort, ctrl_q.allow,
                                   ctrl_q.go, 1'b0};
        // RULE18: key port reads zero
        DEE_KEY_OFS:    rdata_d = 32'h00000000;
        DEE_LOC_OFS:    rdata_d = {24'h000000, loc_q};
        DEE_BYTE_OFS:   rdata_d = {24'h000000, byte_q};
        DEE_STATUS_OFS: rdata_d = {31'h00000000, done_q};
        default:        rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign prdata         = rdata_q;
  assign nvm_busy       = (prg_q == PRG_BUSY);
  assign pmem_row_erase = nvm_busy & ctrl_q.prog_sel & ctrl_q.row_erase;
  assign nvm_done_flag  = done_q;

endmodule

`default_nettype wire

// ### verification/dee_access_ctrl_checker.sv
// Port-level assertions for the data EEPROM access control block
`timescale 1ns/1ps
`default_nettype none
module dee_access_ctrl_checker
  import dee_pkg::*;
#(
  parameter int PROG_COUNT = DEE_PROG_CYCLES
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        pin_reset_req,
  input wire logic        wdt_reset_req,
  input wire logic        nvm_busy,
  input wire logic        pmem_row_erase,
  input wire logic        nvm_done_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic        acc, go_wr, clr_wr, req;
  logic [31:0] cnt_q, cnt_d;
  assign acc    = psel && penable;
  assign go_wr  = acc && pwrite && paddr == DEE_CTRL_OFS && pwdata[DEE_GO_BIT];
  assign clr_wr = acc && pwrite && paddr == DEE_STATUS_OFS && pwdata[DEE_DONE_BIT];
  assign req    = pin_reset_req || wdt_reset_req;
  // Length of the running cycle, cleared whenever idle
  always_comb cnt_d = nvm_busy ? cnt_q + 32'h00000001 : 32'h00000000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_q <= 32'h00000000;
    else cnt_q <= cnt_d;
  end
  sequence s_abort;
    nvm_busy ##0 req;
  endsequence
  sequence s_end;
    $fell(nvm_busy) ##0 !$past(req);
  endsequence
  chk_start_on_go:
    assert property ($rose(nvm_busy) |-> $past(go_wr)) else $error("busy without go write");
  chk_end_sets_done:
    assert property (s_end |-> ##[0:1] nvm_done_flag) else $error("done not set at end");
  chk_done_sw_clear:
    assert property ($fell(nvm_done_flag) |-> $past(clr_wr)) else $error("done cleared alone");
  chk_cycle_length:
    assert property (s_end |-> cnt_q >= PROG_COUNT - 1 && cnt_q <= PROG_COUNT + 1)
      else $error("cycle length wrong");
  chk_abort_stops:
    assert property (s_abort |=> !nvm_busy && !pmem_row_erase) else $error("abort ignored");
  chk_key_reads_zero:
    assert property (acc && !pwrite && paddr == DEE_KEY_OFS |-> prdata == 32'h0)
      else $error("key port not zero");
  chk_ctrl_bit5_zero:
    assert property (acc && !pwrite && paddr == DEE_CTRL_OFS |-> !prdata[5])
      else $error("control bit 5 set");
  chk_row_only_busy:
    assert property (pmem_row_erase |-> nvm_busy) else $error("row erase while idle");
  chk_row_follows_go:
    assert property ($rose(nvm_busy) |->
      pmem_row_erase == $past(pwdata[DEE_PSPACE_BIT] && pwdata[DEE_ROW_BIT]))
      else $error("row erase not as written");
endmodule
bind dee_access_ctrl dee_access_ctrl_checker #(.PROG_COUNT(PROG_COUNT)) dee_access_ctrl_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .pin_reset_req(pin_reset_req), .wdt_reset_req(wdt_reset_req), .nvm_busy(nvm_busy),
  .pmem_row_erase(pmem_row_erase), .nvm_done_flag(nvm_done_flag));
`default_nettype wire

// ### verification/data_eeprom_access_control_tb.sv
// Self-checking testbench for the data EEPROM access control block
`timescale 1ns/1ps
`default_nettype none
module data_eeprom_access_control_tb;
  import dee_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pin_reset_req, wdt_reset_req;
  logic        pready, pslverr, nvm_busy, pmem_row_erase, nvm_done_flag, serr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata;
  int          checks, bad_count;
  logic [7:0]  ra [5] = '{8'h08, 8'h0c, 8'h04, 8'h00, 8'h14};
  logic [7:0]  rw [5] = '{8'h3c, 8'ha5, 8'h55, 8'he8, 8'h77};
  logic [7:0]  re [5] = '{8'h3c, 8'ha5, 8'h00, 8'hc8, 8'h00};
  dee_access_ctrl #(.PROG_COUNT(20)) dee_access_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .pin_reset_req(pin_reset_req), .wdt_reset_req(wdt_reset_req), .nvm_busy(nvm_busy),
    .pmem_row_erase(pmem_row_erase), .nvm_done_flag(nvm_done_flag));
  initial begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end
  task automatic conclude();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // One idle cycle follows each transfer, so no strobe is driven twice in a step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rdata = prdata;
    serr = pslverr;
    psel <= 1'h0; penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic go3(input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] c);
    xfer(1'h1, DEE_KEY_OFS, {24'h0, k1});
    xfer(1'h1, DEE_KEY_OFS, {24'h0, k2});
    xfer(1'h1, DEE_CTRL_OFS, {24'h0, c});
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 100 && nvm_busy !== 1'h0; i++) @(posedge pclk);
  endtask
  initial begin
    repeat (3000) @(posedge pclk);
    bad_count++;
    conclude();
  end
  initial begin
    presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 8'h00;
    pwdata = 32'h0; pin_reset_req = 1'h0; wdt_reset_req = 1'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (int a = 0; a <= 16; a += 4) begin
      xfer(1'h0, a[7:0], 32'h0);
      chk("reset value", 32'h0, rdata);
    end
    for (int i = 0; i < 5; i++) begin
      xfer(1'h1, ra[i], {24'hffffff, rw[i]});
      xfer(1'h0, ra[i], 32'h0);
      chk("row read", {24'h0, re[i]}, rdata);
      chk("row error", {31'h0, ra[i] == 8'h14}, {31'h0, serr});
    end
    xfer(1'h1, DEE_CTRL_OFS, 32'h0);
    go3(8'h55, 8'haa, 8'h06);
    chk("busy same write", 32'h0, {31'h0, nvm_busy});
    go3(8'haa, 8'h55, 8'h06);
    chk("busy bad keys", 32'h0, {31'h0, nvm_busy});
    go3(8'h55, 8'haa, 8'h06);
    chk("busy good keys", 32'h1, {31'h0, nvm_busy});
    xfer(1'h1, DEE_BYTE_OFS, 32'h11);
    xfer(1'h0, DEE_CTRL_OFS, 32'h0);
    chk("ctrl busy", 32'h06, rdata);
    wait_idle();
    chk("done", 32'h1, {31'h0, nvm_done_flag});
    xfer(1'h0, DEE_CTRL_OFS, 32'h0);
    chk("ctrl after", 32'h04, rdata);
    xfer(1'h1, DEE_BYTE_OFS, 32'h0);
    xfer(1'h1, DEE_CTRL_OFS, 32'h85);
    xfer(1'h0, DEE_BYTE_OFS, 32'h0);
    chk("fetch refused", 32'h0, rdata);
    xfer(1'h1, DEE_CTRL_OFS, 32'h45);
    xfer(1'h0, DEE_BYTE_OFS, 32'h0);
    chk("fetch config space", 32'h0, rdata);
    xfer(1'h1, DEE_CTRL_OFS, 32'h05);
    xfer(1'h0, DEE_BYTE_OFS, 32'h0);
    chk("fetched byte", 32'ha5, rdata);
    chk("done kept", 32'h1, {31'h0, nvm_done_flag});
    xfer(1'h1, DEE_STATUS_OFS, 32'h1);
    chk("done cleared", 32'h0, {31'h0, nvm_done_flag});
    xfer(1'h1, DEE_CTRL_OFS, 32'h94);
    go3(8'h55, 8'haa, 8'h96);
    chk("row erase", 32'h1, {31'h0, pmem_row_erase});
    wait_idle();
    xfer(1'h0, DEE_CTRL_OFS, 32'h0);
    chk("row bit cleared", 32'h84, rdata);
    for (int j = 0; j < 2; j++) begin
      xfer(1'h1, DEE_CTRL_OFS, 32'h94);
      go3(8'h55, 8'haa, 8'h96);
      pin_reset_req <= (j == 0);
      wdt_reset_req <= (j == 1);
      @(posedge pclk);
      pin_reset_req <= 1'h0;
      wdt_reset_req <= 1'h0;
      @(posedge pclk);
      chk("busy aborted", 32'h0, {31'h0, nvm_busy});
      xfer(1'h0, DEE_CTRL_OFS, 32'h0);
      chk("ctrl aborted", 32'h98, rdata);
      xfer(1'h0, DEE_LOC_OFS, 32'h0);
      chk("location cleared", 32'h0, rdata);
      xfer(1'h0, DEE_BYTE_OFS, 32'h0);
      chk("byte cleared", 32'h0, rdata);
      chk("done untouched", 32'h1, {31'h0, nvm_done_flag});
    end
    conclude();
  end
endmodule
`default_nettype wire
